/* File: src/dlrt_map.vh */
// register indexes, field positions, reset values and divider counts for the timer block
`ifndef DLRT_MAP_VH
`define DLRT_MAP_VH

// register indexes; byte address on the bus is four times the index
`define DLRT_IDX_TIMER_CONTROL     8'h88
`define DLRT_IDX_MODE_SELECT       8'h89
`define DLRT_IDX_T0_COUNT_LOW      8'h8A
`define DLRT_IDX_T1_COUNT_LOW      8'h8B
`define DLRT_IDX_T0_COUNT_HIGH     8'h8C
`define DLRT_IDX_T1_COUNT_HIGH     8'h8D
`define DLRT_IDX_CLOCK_SELECT      8'h8E
`define DLRT_IDX_RT_CONTROL        8'hC8
`define DLRT_IDX_RT_RELOAD_LOW     8'hCA
`define DLRT_IDX_RT_RELOAD_HIGH    8'hCB
`define DLRT_IDX_RT_COUNT_LOW      8'hCC
`define DLRT_IDX_RT_COUNT_HIGH     8'hCD
`define DLRT_IDX_IRQ_ENABLE        8'hD0

// reset value shared by every register
`define DLRT_RESET_BYTE            8'h00

// timer control fields
`define DLRT_TC_B_OVF              7
`define DLRT_TC_B_RUN              6
`define DLRT_TC_A_OVF              5
`define DLRT_TC_A_RUN              4

// mode select fields
`define DLRT_MS_B_GATE             7
`define DLRT_MS_B_CTR              6
`define DLRT_MS_B_MODE_HI          5
`define DLRT_MS_B_MODE_LO          4
`define DLRT_MS_A_GATE             3
`define DLRT_MS_A_CTR              2
`define DLRT_MS_A_MODE_HI          1
`define DLRT_MS_A_MODE_LO          0

// mode encodings of the legacy timers
`define DLRT_MODE_13BIT            2'h0
`define DLRT_MODE_16BIT            2'h1
`define DLRT_MODE_8RELOAD          2'h2
`define DLRT_MODE_SPLIT            2'h3

// clock select fields
`define DLRT_CS_RT_HIGH_SYS        5
`define DLRT_CS_RT_LOW_SYS         4
`define DLRT_CS_B_SYS              3
`define DLRT_CS_A_SYS              2
`define DLRT_CS_PRESCALE_HI        1
`define DLRT_CS_PRESCALE_LO        0

// prescale encodings
`define DLRT_PRE_DIV12             2'h0
`define DLRT_PRE_DIV4              2'h1
`define DLRT_PRE_DIV48             2'h2
`define DLRT_PRE_EXT8              2'h3

// reload timer control fields
`define DLRT_RC_HIGH_OVF           7
`define DLRT_RC_LOW_OVF            6
`define DLRT_RC_LOW_IRQ_EN         5
`define DLRT_RC_CAPTURE_EN         4
`define DLRT_RC_SPLIT              3
`define DLRT_RC_RUN                2
`define DLRT_RC_EXT_CLK            0

// interrupt enable field
`define DLRT_IE_RT_ENABLE          5

// divider terminal counts
`define DLRT_DIV4_LAST             6'h03
`define DLRT_DIV12_LAST            6'h0B
`define DLRT_DIV48_LAST            6'h2F
`define DLRT_EXT8_LAST             3'h7

`endif

/* File: src/dlrt_timers.v */
// legacy timer pair and split-capable reload timer behind an apb register slave
`timescale 1ns/1ns
`include "dlrt_map.vh"


// three-stage pin synchroniser with agreement filter and edge pulses
module dlrt_pin_sync (
	// clock and reset
	input  wire sys_clk,
	input  wire rst,
	// raw pin
	input  wire pin_in,
	// filtered level and one-cycle edge pulses
	output reg  level_reg,
	output reg  rise_reg,
	output reg  fall_reg
);
	reg s1_reg;	// first stage, read only by the second
	reg s2_reg;	// second stage
	reg s3_reg;	// third stage

	// the level only moves once stages two and three agree on a new value
	always @(posedge sys_clk) begin
		if (rst) begin
			s1_reg    <= 1'b0;
			s2_reg    <= 1'b0;
			s3_reg    <= 1'b0;
			level_reg <= 1'b0;
			rise_reg  <= 1'b0;
			fall_reg  <= 1'b0;
		end else begin
			s1_reg   <= pin_in;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
			if ((s2_reg == s3_reg) && (s3_reg != level_reg)) begin
				level_reg <= s3_reg;
				rise_reg  <= s3_reg;
				fall_reg  <= ~s3_reg;
			end
		end
	end
endmodule

// top of the timer block
module dlrt_timers (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [9:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// external count and gate pins, gate inputs already at active-high sense
	input  wire        count_pin_a,
	input  wire        count_pin_b,
	input  wire        gate_input_a,
	input  wire        gate_input_b,
	// external oscillator and low-frequency oscillator
	input  wire        ext_osc_in,
	input  wire        lfo_in,
	// reload timer interrupt request
	output reg         reload_timer_irq
);
	// software-visible registers
	reg [7:0] legacy_timer_mode_select_reg;	// gating, counter select, modes
	reg [7:0] timer_clock_select_reg;	// clock selects and prescale field
	reg [7:0] timer0_count_low_byte_reg;	// timer a low count
	reg [7:0] timer0_count_high_byte_reg;	// timer a high count
	reg [7:0] timer1_count_low_byte_reg;	// timer b low count
	reg [7:0] timer1_count_high_byte_reg;	// timer b high count
	reg       timer_a_run_reg;	// timer a run
	reg       timer_b_run_reg;	// timer b run
	reg       timer_a_overflow_flag_reg;	// timer a overflow
	reg       timer_b_overflow_flag_reg;	// timer b overflow
	reg [7:0] reload_timer_b_control_reg;	// split, run, flags, enables
	reg [7:0] reload_timer_b_reload_low_reg;	// low reload byte
	reg [7:0] reload_timer_b_reload_high_reg;	// high reload byte
	reg [7:0] reload_timer_b_count_low_reg;	// low count
	reg [7:0] reload_timer_b_count_high_reg;	// high count
	reg       reload_timer_irq_enable_reg;	// interrupt enable for reload timer

	// synchronised pins
	wire pin_a_fall;	// count pin a falling edge
	wire pin_b_fall;	// count pin b falling edge
	wire gate_a_lvl;	// gate input a level
	wire gate_b_lvl;	// gate input b level
	wire ext_osc_rise;	// external oscillator rising edge
	wire lfo_rise;	// low-frequency oscillator capture event

	dlrt_pin_sync u_sync_pin_a (.sys_clk(sys_clk), .rst(rst), .pin_in(count_pin_a),
		.level_reg(), .rise_reg(), .fall_reg(pin_a_fall));
	dlrt_pin_sync u_sync_pin_b (.sys_clk(sys_clk), .rst(rst), .pin_in(count_pin_b),
		.level_reg(), .rise_reg(), .fall_reg(pin_b_fall));
	dlrt_pin_sync u_sync_gate_a (.sys_clk(sys_clk), .rst(rst), .pin_in(gate_input_a),
		.level_reg(gate_a_lvl), .rise_reg(), .fall_reg());
	dlrt_pin_sync u_sync_gate_b (.sys_clk(sys_clk), .rst(rst), .pin_in(gate_input_b),
		.level_reg(gate_b_lvl), .rise_reg(), .fall_reg());
	dlrt_pin_sync u_sync_ext (.sys_clk(sys_clk), .rst(rst), .pin_in(ext_osc_in),
		.level_reg(), .rise_reg(ext_osc_rise), .fall_reg());
	dlrt_pin_sync u_sync_lfo (.sys_clk(sys_clk), .rst(rst), .pin_in(lfo_in),
		.level_reg(), .rise_reg(lfo_rise), .fall_reg());

	// clock dividers
	reg [5:0] div_cnt_reg;	// free-running count for div4 and div48
	reg [5:0] div12_cnt_reg;	// separate count so div12 keeps its own phase
	reg [2:0] ext8_cnt_reg;	// counts synchronised oscillator edges
	reg       div4_tick_reg;	// one pulse per 4 system_clock
	reg       div12_tick_reg;	// one pulse per 12 system_clock
	reg       div48_tick_reg;	// one pulse per 48 system_clock
	reg       ext8_tick_reg;	// one pulse per 8 oscillator edges

	// dividers are ticks rather than derived clocks, so everything stays on sys_clk
	always @(posedge sys_clk) begin
		if (rst) begin
			div_cnt_reg    <= 6'h00;
			div12_cnt_reg  <= 6'h00;
			ext8_cnt_reg   <= 3'h0;
			div4_tick_reg  <= 1'b0;
			div12_tick_reg <= 1'b0;
			div48_tick_reg <= 1'b0;
			ext8_tick_reg  <= 1'b0;
		end else begin
			div_cnt_reg    <= (div_cnt_reg == `DLRT_DIV48_LAST) ? 6'h00 : div_cnt_reg + 6'h01;
			div12_cnt_reg  <= (div12_cnt_reg == `DLRT_DIV12_LAST) ? 6'h00 :
				div12_cnt_reg + 6'h01;
			div4_tick_reg  <= (div_cnt_reg[1:0] == `DLRT_DIV4_LAST);
			div12_tick_reg <= (div12_cnt_reg == `DLRT_DIV12_LAST);
			div48_tick_reg <= (div_cnt_reg == `DLRT_DIV48_LAST);
			// oscillator edges come through the synchroniser first
			ext8_tick_reg  <= ext_osc_rise && (ext8_cnt_reg == `DLRT_EXT8_LAST);
			if (ext_osc_rise) begin
				ext8_cnt_reg <= ext8_cnt_reg + 3'h1;
			end
		end
	end

	// field decode
	wire [1:0] timer_a_mode_field =
		legacy_timer_mode_select_reg[`DLRT_MS_A_MODE_HI:`DLRT_MS_A_MODE_LO];
	wire [1:0] timer_b_mode_field =
		legacy_timer_mode_select_reg[`DLRT_MS_B_MODE_HI:`DLRT_MS_B_MODE_LO];
	wire timer_a_pin_gating = legacy_timer_mode_select_reg[`DLRT_MS_A_GATE];
	wire timer_b_pin_gating = legacy_timer_mode_select_reg[`DLRT_MS_B_GATE];
	wire timer_a_counter_select = legacy_timer_mode_select_reg[`DLRT_MS_A_CTR];
	wire timer_b_counter_select = legacy_timer_mode_select_reg[`DLRT_MS_B_CTR];
	wire timer_a_system_clock_select = timer_clock_select_reg[`DLRT_CS_A_SYS];
	wire timer_b_system_clock_select = timer_clock_select_reg[`DLRT_CS_B_SYS];
	wire [1:0] prescale_field =
		timer_clock_select_reg[`DLRT_CS_PRESCALE_HI:`DLRT_CS_PRESCALE_LO];
	wire reload_timer_high_clk_sel = timer_clock_select_reg[`DLRT_CS_RT_HIGH_SYS];
	wire reload_timer_low_clk_sel = timer_clock_select_reg[`DLRT_CS_RT_LOW_SYS];
	wire reload_timer_ext_clk_sel = reload_timer_b_control_reg[`DLRT_RC_EXT_CLK];
	wire reload_timer_split_mode = reload_timer_b_control_reg[`DLRT_RC_SPLIT];
	wire reload_timer_run = reload_timer_b_control_reg[`DLRT_RC_RUN];
	wire reload_timer_low_irq_enable = reload_timer_b_control_reg[`DLRT_RC_LOW_IRQ_EN];
	wire reload_timer_lfo_capture_enable = reload_timer_b_control_reg[`DLRT_RC_CAPTURE_EN];
	wire reload_timer_high_ovf_flag = reload_timer_b_control_reg[`DLRT_RC_HIGH_OVF];
	wire reload_timer_low_ovf_flag = reload_timer_b_control_reg[`DLRT_RC_LOW_OVF];

	// prescaled tick shared by the legacy timers
	reg pre_tick;
	always @* begin
		case (prescale_field)
			`DLRT_PRE_DIV12: pre_tick = div12_tick_reg;
			`DLRT_PRE_DIV4:  pre_tick = div4_tick_reg;
			`DLRT_PRE_DIV48: pre_tick = div48_tick_reg;
			default:         pre_tick = ext8_tick_reg;
		endcase
	end

	// one count step of a legacy timer: {overflow, high, low}
	function [16:0] dlrt_legacy_step;
		input [1:0] mode;
		input [7:0] hi;
		input [7:0] lo;
		reg   [12:0] c13;
		reg   [15:0] c16;
		begin
			c13 = {hi, lo[4:0]} + 13'h0001;
			c16 = {hi, lo} + 16'h0001;
			case (mode)
				`DLRT_MODE_13BIT:	// upper three low bits are left untouched
					dlrt_legacy_step = {(&{hi, lo[4:0]}), c13[12:5], lo[7:5], c13[4:0]};
				`DLRT_MODE_16BIT:
					dlrt_legacy_step = {(&{hi, lo}), c16};
				`DLRT_MODE_8RELOAD:	// high byte is the reload value and stays as is
					dlrt_legacy_step = (lo == 8'hFF) ? {1'b1, hi, hi} :
						{1'b0, hi, lo + 8'h01};
				default:	// split: only the low byte counts here
					dlrt_legacy_step = {(lo == 8'hFF), hi, lo + 8'h01};
			endcase
		end
	endfunction

	// legacy timer stepping
	wire a_split = (timer_a_mode_field == `DLRT_MODE_SPLIT);
	wire a_run = timer_a_run_reg && (!timer_a_pin_gating || gate_a_lvl);
	wire a_tick = timer_a_counter_select ? pin_a_fall :
		(timer_a_system_clock_select ? 1'b1 : pre_tick);
	wire a_high_tick = timer_b_run_reg && (timer_a_system_clock_select ? 1'b1 : pre_tick);
	// while timer a is split, timer b runs from its mode alone and ignores its pin
	wire b_run = a_split ? 1'b1 :
		(timer_b_run_reg && (!timer_b_pin_gating || gate_b_lvl));
	wire b_tick = (timer_b_counter_select && !a_split) ? pin_b_fall :
		(timer_b_system_clock_select ? 1'b1 : pre_tick);
	wire b_active = (timer_b_mode_field != `DLRT_MODE_SPLIT);
	wire [16:0] a_step = dlrt_legacy_step(timer_a_mode_field, timer0_count_high_byte_reg,
		timer0_count_low_byte_reg);
	wire [16:0] b_step = dlrt_legacy_step(timer_b_mode_field, timer1_count_high_byte_reg,
		timer1_count_low_byte_reg);

	reg [7:0] t0_lo_next;	// next timer a low
	reg [7:0] t0_hi_next;	// next timer a high
	reg [7:0] t1_lo_next;	// next timer b low
	reg [7:0] t1_hi_next;	// next timer b high
	reg       a_ovf_set;	// timer a overflow event
	reg       b_ovf_set;	// timer b overflow event

	// hardware next values before software writes are applied
	always @* begin
		t0_lo_next = timer0_count_low_byte_reg;
		t0_hi_next = timer0_count_high_byte_reg;
		t1_lo_next = timer1_count_low_byte_reg;
		t1_hi_next = timer1_count_high_byte_reg;
		a_ovf_set  = 1'b0;
		b_ovf_set  = 1'b0;
		if (a_run && a_tick) begin
			t0_lo_next = a_step[7:0];
			t0_hi_next = a_step[15:8];
			a_ovf_set  = a_step[16];
		end
		// split high byte borrows timer b run and flag
		if (a_split && a_high_tick) begin
			t0_hi_next = timer0_count_high_byte_reg + 8'h01;
			b_ovf_set  = (timer0_count_high_byte_reg == 8'hFF);
		end
		if (b_active && b_run && b_tick) begin
			t1_lo_next = b_step[7:0];
			t1_hi_next = b_step[15:8];
			if (!a_split) begin
				b_ovf_set = b_step[16];
			end
		end
	end

	// reload timer stepping
	wire rt_lo_tick = reload_timer_low_clk_sel ? 1'b1 :
		(reload_timer_ext_clk_sel ? ext8_tick_reg : div12_tick_reg);
	wire rt_hi_tick = reload_timer_high_clk_sel ? 1'b1 :
		(reload_timer_ext_clk_sel ? ext8_tick_reg : div12_tick_reg);

	reg [7:0] rt_lo_next;	// next low count
	reg [7:0] rt_hi_next;	// next high count
	reg       rt_hi_ovf_set;	// high overflow event
	reg       rt_lo_ovf_set;	// low overflow event

	always @* begin
		rt_lo_next    = reload_timer_b_count_low_reg;
		rt_hi_next    = reload_timer_b_count_high_reg;
		rt_hi_ovf_set = 1'b0;
		rt_lo_ovf_set = 1'b0;
		if (!reload_timer_split_mode) begin
			// whole timer on the low clock select; high select has no effect
			if (reload_timer_run && rt_lo_tick) begin
				rt_lo_ovf_set = (reload_timer_b_count_low_reg == 8'hFF);
				if ({reload_timer_b_count_high_reg, reload_timer_b_count_low_reg} == 16'hFFFF) begin
					rt_lo_next    = reload_timer_b_reload_low_reg;
					rt_hi_next    = reload_timer_b_reload_high_reg;
					rt_hi_ovf_set = 1'b1;
				end else begin
					{rt_hi_next, rt_lo_next} = {reload_timer_b_count_high_reg,
						reload_timer_b_count_low_reg} + 16'h0001;
				end
			end
		end else begin
			// low half free-runs in split mode
			if (rt_lo_tick) begin
				rt_lo_ovf_set = (reload_timer_b_count_low_reg == 8'hFF);
				rt_lo_next = rt_lo_ovf_set ? reload_timer_b_reload_low_reg :
					reload_timer_b_count_low_reg + 8'h01;
			end
			if (reload_timer_run && rt_hi_tick) begin
				rt_hi_ovf_set = (reload_timer_b_count_high_reg == 8'hFF);
				rt_hi_next = rt_hi_ovf_set ? reload_timer_b_reload_high_reg :
					reload_timer_b_count_high_reg + 8'h01;
			end
		end
	end

	// capture of the running count on a low-frequency oscillator edge
	wire rt_capture = reload_timer_lfo_capture_enable && reload_timer_run && lfo_rise;

	// apb decode
	wire [7:0] idx = paddr[9:2];	// register index
	wire       aligned = (paddr[1:0] == 2'h0);	// byte address must be word aligned
	wire       wr_fire = psel && penable && pready && pwrite && aligned;	// write lands here
	reg  [7:0] rd_byte;	// read mux
	reg        hit;	// address maps to a register

	always @* begin
		hit = 1'b1;
		case (idx)
			`DLRT_IDX_TIMER_CONTROL: rd_byte = {timer_b_overflow_flag_reg, timer_b_run_reg,
				timer_a_overflow_flag_reg, timer_a_run_reg, 4'h0};
			`DLRT_IDX_MODE_SELECT:    rd_byte = legacy_timer_mode_select_reg;
			`DLRT_IDX_T0_COUNT_LOW:   rd_byte = timer0_count_low_byte_reg;
			`DLRT_IDX_T1_COUNT_LOW:   rd_byte = timer1_count_low_byte_reg;
			`DLRT_IDX_T0_COUNT_HIGH:  rd_byte = timer0_count_high_byte_reg;
			`DLRT_IDX_T1_COUNT_HIGH:  rd_byte = timer1_count_high_byte_reg;
			`DLRT_IDX_CLOCK_SELECT:   rd_byte = timer_clock_select_reg;
			`DLRT_IDX_RT_CONTROL:     rd_byte = reload_timer_b_control_reg;
			`DLRT_IDX_RT_RELOAD_LOW:  rd_byte = reload_timer_b_reload_low_reg;
			`DLRT_IDX_RT_RELOAD_HIGH: rd_byte = reload_timer_b_reload_high_reg;
			`DLRT_IDX_RT_COUNT_LOW:   rd_byte = reload_timer_b_count_low_reg;
			`DLRT_IDX_RT_COUNT_HIGH:  rd_byte = reload_timer_b_count_high_reg;
			`DLRT_IDX_IRQ_ENABLE:     rd_byte = {2'h0, reload_timer_irq_enable_reg, 5'h00};
			default: begin
				rd_byte = 8'h00;
				hit     = 1'b0;
			end
		endcase
	end

	// apb handshake: one wait state, so the read sample and write edge are well defined
	always @(posedge sys_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !(hit && aligned);
			if (psel && penable && !pready) begin
				prdata <= (hit && aligned && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
			end
		end
	end

	wire [7:0] wb = pwdata[7:0];	// written byte
	wire wr_tc = wr_fire && (idx == `DLRT_IDX_TIMER_CONTROL);
	wire wr_rc = wr_fire && (idx == `DLRT_IDX_RT_CONTROL);

	// register file; a software write to a count beats the hardware step
	always @(posedge sys_clk) begin
		if (rst) begin
			legacy_timer_mode_select_reg   <= `DLRT_RESET_BYTE;
			timer_clock_select_reg         <= `DLRT_RESET_BYTE;
			timer0_count_low_byte_reg      <= `DLRT_RESET_BYTE;
			timer0_count_high_byte_reg     <= `DLRT_RESET_BYTE;
			timer1_count_low_byte_reg      <= `DLRT_RESET_BYTE;
			timer1_count_high_byte_reg     <= `DLRT_RESET_BYTE;
			timer_a_run_reg                <= 1'b0;
			timer_b_run_reg                <= 1'b0;
			timer_a_overflow_flag_reg      <= 1'b0;
			timer_b_overflow_flag_reg      <= 1'b0;
			reload_timer_b_control_reg     <= `DLRT_RESET_BYTE;
			reload_timer_b_reload_low_reg  <= `DLRT_RESET_BYTE;
			reload_timer_b_reload_high_reg <= `DLRT_RESET_BYTE;
			reload_timer_b_count_low_reg   <= `DLRT_RESET_BYTE;
			reload_timer_b_count_high_reg  <= `DLRT_RESET_BYTE;
			reload_timer_irq_enable_reg    <= 1'b0;
			reload_timer_irq               <= 1'b0;
		end else begin
			legacy_timer_mode_select_reg <= (wr_fire && idx == `DLRT_IDX_MODE_SELECT) ?
				wb : legacy_timer_mode_select_reg;
			timer_clock_select_reg <= (wr_fire && idx == `DLRT_IDX_CLOCK_SELECT) ?
				wb : timer_clock_select_reg;
			timer0_count_low_byte_reg <= (wr_fire && idx == `DLRT_IDX_T0_COUNT_LOW) ?
				wb : t0_lo_next;
			timer0_count_high_byte_reg <= (wr_fire && idx == `DLRT_IDX_T0_COUNT_HIGH) ?
				wb : t0_hi_next;
			timer1_count_low_byte_reg <= (wr_fire && idx == `DLRT_IDX_T1_COUNT_LOW) ?
				wb : t1_lo_next;
			timer1_count_high_byte_reg <= (wr_fire && idx == `DLRT_IDX_T1_COUNT_HIGH) ?
				wb : t1_hi_next;
			// flags: a hardware set in the clearing cycle wins
			timer_a_run_reg <= wr_tc ? wb[`DLRT_TC_A_RUN] : timer_a_run_reg;
			timer_b_run_reg <= wr_tc ? wb[`DLRT_TC_B_RUN] : timer_b_run_reg;
			timer_a_overflow_flag_reg <= (wr_tc ? wb[`DLRT_TC_A_OVF] :
				timer_a_overflow_flag_reg) | a_ovf_set;
			timer_b_overflow_flag_reg <= (wr_tc ? wb[`DLRT_TC_B_OVF] :
				timer_b_overflow_flag_reg) | b_ovf_set;
			// reload timer control; bit 1 always reads zero
			reload_timer_b_control_reg <= {
				(wr_rc ? wb[`DLRT_RC_HIGH_OVF] : reload_timer_high_ovf_flag) | rt_hi_ovf_set,
				(wr_rc ? wb[`DLRT_RC_LOW_OVF] : reload_timer_low_ovf_flag) | rt_lo_ovf_set,
				wr_rc ? {wb[5:2], 1'b0, wb[0]} : reload_timer_b_control_reg[5:0]};
			// capture takes priority over a write to the reload bytes
			if (rt_capture) begin
				reload_timer_b_reload_low_reg  <= reload_timer_b_count_low_reg;
				reload_timer_b_reload_high_reg <= reload_timer_b_count_high_reg;
			end else begin
				if (wr_fire && idx == `DLRT_IDX_RT_RELOAD_LOW) begin
					reload_timer_b_reload_low_reg <= wb;
				end
				if (wr_fire && idx == `DLRT_IDX_RT_RELOAD_HIGH) begin
					reload_timer_b_reload_high_reg <= wb;
				end
			end
			reload_timer_b_count_low_reg <= (wr_fire && idx == `DLRT_IDX_RT_COUNT_LOW) ?
				wb : rt_lo_next;
			reload_timer_b_count_high_reg <= (wr_fire && idx == `DLRT_IDX_RT_COUNT_HIGH) ?
				wb : rt_hi_next;
			reload_timer_irq_enable_reg <= (wr_fire && idx == `DLRT_IDX_IRQ_ENABLE) ?
				wb[`DLRT_IE_RT_ENABLE] : reload_timer_irq_enable_reg;
			// request level follows the flags; low flag counts only with its enable
			reload_timer_irq <= reload_timer_irq_enable_reg &&
				(reload_timer_high_ovf_flag ||
				(reload_timer_low_irq_enable && reload_timer_low_ovf_flag));
		end
	end
endmodule

/* File: dv/dlrt_asserts.sv */
// port checks of the timer block: apb answer timing and interrupt line
`timescale 1ns/1ns
module dlrt_asserts (
	// clock and reset
	input wire        sys_clk,
	input wire        rst,
	// apb and interrupt
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [9:0]  paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        reload_timer_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// an access waiting, and its answer
	sequence s_req; psel && penable && !pready; endsequence
	sequence s_ans; psel && penable && pready; endsequence
	a_ready_wait: assert property (s_req |=> s_ans) else $error("late pready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("high bits");
	a_err_rdata: assert property (s_ans ##0 pslverr && !pwrite |-> prdata == 32'h00000000)
		else $error("refused read data");
	a_err_unmapped: assert property (pready && paddr[9:2] == 8'h00 |-> pslverr)
		else $error("unmapped accepted");
	// irq only falls after a software write, the flags being sticky
	a_irq_sticky: assert property ($fell(reload_timer_irq) |->
		$past(pready && pwrite, 2) || $past(pready && pwrite, 3)) else $error("irq fell");
endmodule
bind dlrt_timers dlrt_asserts u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .reload_timer_irq);

/* File: dv/dlrt_partner.sv */
// pins around the timer block: count bursts, gate level, free oscillators
`timescale 1ns/1ns
module dlrt_partner (
	// clock
	input  wire       sys_clk,
	// bench asks for a burst of falling edges, and sets the gate level
	input  wire       go,
	input  wire [3:0] go_count,
	input  wire       gate_on,
	// pins toward the block
	output reg        count_pin_a,
	output wire       count_pin_b,
	output wire       gate_input_a,
	output wire       gate_input_b,
	output wire       ext_osc_in,
	output wire       lfo_in,
	// burst still running
	output wire       busy
);
	reg [3:0] ph = 4'h0;   // free phase counter
	reg [3:0] left = 4'h0; // edges still owed
	initial count_pin_a = 1'b1;
	// oscillators run free; slow enough for the three-flop filter
	assign ext_osc_in = ph[2];
	assign lfo_in = ph[3];
	assign count_pin_b = ph[1];
	assign gate_input_a = gate_on;
	assign gate_input_b = gate_on;
	assign busy = (left != 4'h0) || !count_pin_a;
	// lows start only at phase 8, so no pulse is shorter than the filter
	always @(posedge sys_clk) begin
		ph <= ph + 4'h1;
		if (ph == 4'h8 && left != 4'h0) count_pin_a <= 1'b0;
		if (ph == 4'h0 && !count_pin_a) begin
			count_pin_a <= 1'b1;
			left <= left - 4'h1;
		end
		if (go) left <= go_count;
	end
endmodule

/* File: dv/dlrt_timers_bench.sv */
// self-checking bench for the timer block
`timescale 1ns/1ns
`include "dlrt_map.vh"
module dlrt_timers_bench;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic        go = 1'b0;
	logic [3:0]  go_count = 4'h0;
	logic        gate_on = 1'b0;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, pa, pb, ga, gb, osc, lfo, busy;
	int          fail_count = 0;
	int          cmp_count = 0;
	always #25 sys_clk = ~sys_clk;
	dlrt_timers dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .count_pin_a(pa), .count_pin_b(pb), .gate_input_a(ga),
		.gate_input_b(gb), .ext_osc_in(osc), .lfo_in(lfo), .reload_timer_irq(irq));
	dlrt_partner u_far (.sys_clk, .go, .go_count, .gate_on, .count_pin_a(pa),
		.count_pin_b(pb), .gate_input_a(ga), .gate_input_b(gb), .ext_osc_in(osc),
		.lfo_in(lfo), .busy);
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] i, input logic [7:0] d,
		output logic [7:0] r, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] r;
		logic       e;
		apb(1'b1, i, d, r, e);
	endtask
	// byte read compared under a mask; an error answer is a mismatch too
	task chk(input string n, input logic [7:0] i, input logic [7:0] x, input logic [7:0] m);
		logic [7:0] r;
		logic       e;
		apb(1'b0, i, 8'h00, r, e);
		cmp_count++;
		if ((r & m) !== (x & m) || e !== 1'b0) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, x, r);
		end
	endtask
	task chk_bit(input string n, input logic x, input logic s);
		cmp_count++;
		if (s !== x) begin
			fail_count++;
			$display("unexpected %s: expected %b seen %b", n, x, s);
		end
	endtask
	// falling-edge burst, then the synchroniser's latency
	task pulses(input logic [3:0] n);
		go_count <= n;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		while (busy) @(posedge sys_clk);
		repeat (8) @(posedge sys_clk);
	endtask
	task t_regs;
		logic [7:0] r;
		logic       e;
		chk("rtctl", `DLRT_IDX_RT_CONTROL, 8'h00, 8'hFF);
		wr(`DLRT_IDX_T1_COUNT_HIGH, 8'hA5);
		chk("t1h", `DLRT_IDX_T1_COUNT_HIGH, 8'hA5, 8'hFF);
		apb(1'b0, 8'h00, 8'h00, r, e);
		chk_bit("unmapped", 1'b1, e);
	endtask
	// timer a on system_clock, 8-bit reload: flag inside a few cycles, low from high
	task t_reload8;
		wr(`DLRT_IDX_CLOCK_SELECT, 8'h04);
		wr(`DLRT_IDX_MODE_SELECT, 8'h02);
		wr(`DLRT_IDX_T0_COUNT_HIGH, 8'h80);
		wr(`DLRT_IDX_T0_COUNT_LOW, 8'hFF);
		wr(`DLRT_IDX_TIMER_CONTROL, 8'h10);
		chk("t0 flag", `DLRT_IDX_TIMER_CONTROL, 8'h30, 8'hF0);
		chk("t0 low", `DLRT_IDX_T0_COUNT_LOW, 8'h80, 8'h80);
		wr(`DLRT_IDX_TIMER_CONTROL, 8'h00);
	endtask
	// pin edges counted only with the gate open
	task t_count;
		wr(`DLRT_IDX_MODE_SELECT, 8'h0D);
		wr(`DLRT_IDX_T0_COUNT_LOW, 8'h00);
		wr(`DLRT_IDX_TIMER_CONTROL, 8'h10);
		pulses(4'h2);
		chk("gated", `DLRT_IDX_T0_COUNT_LOW, 8'h00, 8'hFF);
		gate_on <= 1'b1;
		pulses(4'h3);
		chk("counted", `DLRT_IDX_T0_COUNT_LOW, 8'h03, 8'hFF);
		wr(`DLRT_IDX_TIMER_CONTROL, 8'h00);
	endtask
	// reload timer, 16-bit rollover with the interrupt enabled
	task t_rt16;
		wr(`DLRT_IDX_CLOCK_SELECT, 8'h10);
		wr(`DLRT_IDX_RT_RELOAD_HIGH, 8'h12);
		wr(`DLRT_IDX_RT_COUNT_LOW, 8'hFF);
		wr(`DLRT_IDX_RT_COUNT_HIGH, 8'hFF);
		wr(`DLRT_IDX_IRQ_ENABLE, 8'h20);
		wr(`DLRT_IDX_RT_CONTROL, 8'h04);
		chk("rt high", `DLRT_IDX_RT_COUNT_HIGH, 8'h12, 8'hFF);
		chk("rt flag", `DLRT_IDX_RT_CONTROL, 8'h84, 8'hBF);
		chk_bit("rt irq", 1'b1, irq);
		wr(`DLRT_IDX_RT_CONTROL, 8'h00);
		repeat (3) @(posedge sys_clk);
		chk_bit("irq clear", 1'b0, irq);
	endtask
	// split: low half free-running with its own reload, high half held by run
	task t_split;
		wr(`DLRT_IDX_RT_RELOAD_LOW, 8'h40);
		wr(`DLRT_IDX_RT_COUNT_HIGH, 8'h55);
		wr(`DLRT_IDX_RT_COUNT_LOW, 8'hFF);
		wr(`DLRT_IDX_RT_CONTROL, 8'h08);
		chk("split high", `DLRT_IDX_RT_COUNT_HIGH, 8'h55, 8'hFF);
		chk("split low", `DLRT_IDX_RT_COUNT_LOW, 8'h40, 8'hC0);
		chk("split flags", `DLRT_IDX_RT_CONTROL, 8'h48, 8'hFF);
		chk_bit("split irq", 1'b0, irq);
	endtask
	// capture: 16-bit running count copied into reload bytes on an lfo edge
	task t_capture;
		wr(`DLRT_IDX_RT_CONTROL, 8'h14);
		repeat (24) @(posedge sys_clk);
		chk("captured", `DLRT_IDX_RT_RELOAD_HIGH, 8'h55, 8'hFF);
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_reload8;
		t_count;
		t_rt16;
		t_split;
		t_capture;
		finish_test;
	end
	// watchdog: the run needs well under this
	initial begin
		#200000;
		fail_count++;
		finish_test;
	end
endmodule
